//--- pkg/bbsd_pkg.sv
// Behaviour
// - Opcode 1101 is relative jump, 11-bit offset
// - Jump offset is signed, -1024 to 1023
// - Jump target is incremented PC plus twice offset
// - Jump takes two cycles, second flushed nop
// - Opcode 1000 sets chosen bit, flags untouched
// - Access bit zero: access bank; one: bank register
// - Extended set, access zero, f<=95: indexed offset
// - Bit set: one cycle, write back in Q4
// - Skip discards prefetch, runs nop, two cycles
package bbsd_pkg;
   localparam logic [3:0]  OPC_JUMP      = 4'hd;
   localparam logic [3:0]  OPC_BIT_SET   = 4'h8;
   localparam logic [3:0]  OPC_SKIP_SET  = 4'ha;
   localparam logic [3:0]  OPC_SKIP_CLR  = 4'hb;
   localparam int          OPC_MSB       = 15;
   localparam int          OPC_LSB       = 12;
   localparam int          OFS_MSB       = 10;
   localparam int          BIT_MSB       = 11;
   localparam int          BIT_LSB       = 9;
   localparam int          ACC_POS       = 8;
   localparam int          FILE_MSB      = 7;
   localparam logic [7:0]  INDEXED_LIMIT = 8'h5f;
   localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
   localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
   localparam int          PC_W          = 21;
   localparam int          ADDR_W        = 12;
   localparam logic [1:0]  Q1            = 2'h0;
   localparam logic [1:0]  Q4            = 2'h3;

   typedef struct packed {
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } bbsd_fwr_s;

   typedef struct packed {
      logic            load;
      logic [PC_W-1:0] target;
   } bbsd_pcld_s;
endpackage

//--- hdl/bbsd_addr_gen.sv
`timescale 1ns/1ps
// Resolves an 8-bit file operand to a full data address
module bbsd_addr_gen
   import bbsd_pkg::*;
(
   input  wire logic [7:0]        file_op,
   input  wire logic              access_a,
   input  wire logic [3:0]        bank_select_register,
   input  wire logic              ext_set_en,
   input  wire logic [ADDR_W-1:0] index_base,
   output logic      [ADDR_W-1:0] addr
);
   // Indexed mode adds the operand to the index pointer instead of the access bank
   always_comb
   begin
      if (access_a)
         addr = {bank_select_register, file_op};
      else if (ext_set_en && (file_op <= INDEXED_LIMIT))
         addr = index_base + {4'h0, file_op};
      else if (file_op < ACCESS_SPLIT)
         addr = {4'h0, file_op};
      else
         addr = {ACCESS_HI_BANK, file_op};
   end
endmodule

//--- hdl/bbsd_decode.sv
`timescale 1ns/1ps
// Executes jump, bit-set and bit-test-skip instructions over four phases
module bbsd_decode
   import bbsd_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic [15:0]       instr,
   input  wire logic              instr_valid,
   input  wire logic [PC_W-1:0]   pc_inc,
   input  wire logic [3:0]        bank_select_register,
   input  wire logic              ext_set_en,
   input  wire logic [ADDR_W-1:0] index_base,
   input  wire logic [7:0]        file_rd_data,
   output logic      [1:0]        q_phase,
   output logic      [ADDR_W-1:0] file_rd_addr,
   output bbsd_pkg::bbsd_fwr_s    file_wr,
   output bbsd_pkg::bbsd_pcld_s   pc_load,
   output logic                   flush,
   output logic                   busy
);
   import bbsd_pkg::*;

   typedef enum logic [1:0] {
      BBSD_EXEC  = 2'b00,
      BBSD_FLUSH = 2'b01
   } bbsd_state_e;

   bbsd_state_e       state_q;
   logic [1:0]        q_q;
   logic [15:0]       ir_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0]        data_q;
   logic              skip_q;
   logic [ADDR_W-1:0] addr_d;
   logic [3:0]        opc;
   logic [2:0]        bit_sel;
   logic              is_jump;
   logic              is_set;
   logic              is_test;
   logic signed [PC_W-1:0] ofs_ext;
   bbsd_fwr_s         file_wr_q;
   bbsd_pcld_s        pc_load_q;
   logic              flush_q;

   // Field extraction from the latched word
   assign opc     = ir_q[OPC_MSB:OPC_LSB];
   assign bit_sel = ir_q[BIT_MSB:BIT_LSB];
   assign is_jump = (opc == OPC_JUMP);
   assign is_set  = (opc == OPC_BIT_SET);
   assign is_test = (opc == OPC_SKIP_CLR) || (opc == OPC_SKIP_SET);
   // Sign-extend the 11-bit field so -1024..1023 is covered
   assign ofs_ext = PC_W'(signed'(ir_q[OFS_MSB:0]));

   bbsd_addr_gen u_addr
   (
      .file_op              (ir_q[FILE_MSB:0]),
      .access_a             (ir_q[ACC_POS]),
      .bank_select_register (bank_select_register),
      .ext_set_en           (ext_set_en),
      .index_base           (index_base),
      .addr                 (addr_d)
   );

   // Phase counter: Q1..Q4 repeat every instruction cycle
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         q_q <= Q1;
      else
         q_q <= q_q + 2'h1;
   end

   // Instruction latch in Q4; a zero word is latched for the flush cycle after a jump or taken skip
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ir_q <= 16'h0000;
      else if (q_q == Q4)
      begin
         if (instr_valid && !(state_q == BBSD_EXEC && (pc_load_q.load || skip_q)))
            ir_q <= instr;
         else
            ir_q <= 16'h0000; // Zero word decodes as none of ours: a nop
      end
   end

   // Read address captured in Q1, data captured in Q2, data processed in Q3
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         addr_q <= '0;
         data_q <= 8'h00;
      end
      else if (q_q == 2'h0)
         addr_q <= addr_d;
      else if (q_q == 2'h1)
         data_q <= file_rd_data;
      else if (q_q == 2'h2 && is_set && state_q == BBSD_EXEC)
         data_q <= data_q | (8'h01 << bit_sel);
   end

   // Bit test decides the skip in Q3
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         skip_q <= 1'b0;
      else if (q_q == 2'h2)
      begin
         if (state_q == BBSD_EXEC && is_test)
         begin
            if (opc == OPC_SKIP_SET)
               skip_q <= data_q[bit_sel];
            else
               skip_q <= ~data_q[bit_sel];
         end
         else
            skip_q <= 1'b0;
      end
   end

   // Q4 write-back and PC load; flags are never touched here
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         file_wr_q <= '0;
         pc_load_q <= '0;
      end
      else if (q_q == 2'h2 && state_q == BBSD_EXEC)
      begin
         file_wr_q.we     <= is_set;
         file_wr_q.addr   <= addr_q;
         file_wr_q.data   <= data_q | (8'h01 << bit_sel);
         pc_load_q.load   <= is_jump;
         pc_load_q.target <= pc_inc + PC_W'(ofs_ext <<< 1);
      end
      else
      begin
         file_wr_q.we   <= 1'b0;
         pc_load_q.load <= 1'b0;
      end
   end

   // Second cycle after a jump or taken skip is a flushed nop
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= BBSD_EXEC;
         flush_q <= 1'b0;
      end
      else if (q_q == Q4)
      begin
         if (state_q == BBSD_EXEC && (pc_load_q.load || skip_q))
         begin
            state_q <= BBSD_FLUSH;
            flush_q <= 1'b1;
         end
         else
         begin
            state_q <= BBSD_EXEC;
            flush_q <= 1'b0;
         end
      end
   end

   // Outputs straight from flops
   assign q_phase      = q_q;
   assign file_rd_addr = addr_q;
   assign file_wr      = file_wr_q;
   assign pc_load      = pc_load_q;
   assign flush        = flush_q;
   assign busy         = flush_q;
endmodule

//--- verification/bbsd_decode_chk.sv
`timescale 1ns/1ps
module bbsd_decode_chk
(
   input wire logic                      clk,
   input wire logic                      reset_n,
   input wire logic [15:0]               instr,
   input wire logic                      instr_valid,
   input wire logic [bbsd_pkg::PC_W-1:0] pc_inc,
   input wire logic [7:0]                file_rd_data,
   input wire logic [1:0]                q_phase,
   input wire logic [11:0]               file_rd_addr,
   input wire bbsd_pkg::bbsd_fwr_s       file_wr,
   input wire bbsd_pkg::bbsd_pcld_s      pc_load,
   input wire logic                      flush,
   input wire logic                      busy
);
   import bbsd_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Strobes belong to the last phase only
   chk_load_phase: assert property (pc_load.load |-> q_phase == Q4)
      else $error("jump load outside last phase");
   chk_write_phase: assert property (file_wr.we |-> q_phase == Q4 && !pc_load.load)
      else $error("write outside last phase");
   // Target uses the Q3 counter and the latched offset
   chk_jump_target: assert property (pc_load.load |-> pc_load.target == $past(pc_inc)
      + {{9{$past(instr[10],4)}}, $past(instr[10:0],4), 1'b0}) else $error("bad jump target");
   chk_set_data: assert property (file_wr.we |-> file_wr.data ==
      ($past(file_rd_data,2) | (8'h01 << $past(instr[11:9],4)))) else $error("bad set data");
   chk_write_addr: assert property (file_wr.we |-> file_wr.addr == file_rd_addr)
      else $error("write address differs");
   chk_jump_flush: assert property ($rose(pc_load.load) |=> flush[*4] ##1 !flush)
      else $error("flush not four clocks");
   chk_busy_flush: assert property (flush == busy)
      else $error("busy differs from flush");
   chk_jump_start: assert property (q_phase == Q4 && instr_valid && instr[15:12] == OPC_JUMP
      && !busy && !pc_load.load |-> ##4 pc_load.load) else $error("jump not run");
endmodule
bind bbsd_decode bbsd_decode_chk u_chk (.clk, .reset_n, .instr, .instr_valid, .pc_inc,
   .file_rd_data, .q_phase, .file_rd_addr, .file_wr, .pc_load, .flush, .busy);

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
   import bbsd_pkg::*;
   typedef struct packed {
      logic [15:0] ins;
      logic        ext;
      logic [7:0]  rd;
      logic [11:0] adr;
      logic [2:0]  lwf;
      logic [20:0] val;
   } bbsd_row_s;
   logic        clk = 0;
   logic        reset_n = 0;
   logic [15:0] instr = 16'h0000;
   logic        instr_valid = 0;
   logic        ext_set_en = 0;
   logic [7:0]  file_rd_data = 8'h00;
   logic [1:0]  q_phase;
   logic [11:0] file_rd_addr;
   bbsd_fwr_s   file_wr;
   bbsd_pcld_s  pc_load;
   logic        flush;
   logic        busy;
   int          num_errors = 0;
   int          comparisons = 0;
   // Load, write, flush flags; value is target or written byte
   bbsd_row_s rows [10] = '{
      '{16'hd3ff, 1'h0, 8'h00, 12'h000, 3'h5, 21'h0017fe},
      '{16'hd400, 1'h0, 8'h00, 12'h000, 3'h5, 21'h000800},
      '{16'h8f0a, 1'h0, 8'h0a, 12'h30a, 3'h2, 21'h00008a},
      '{16'h8060, 1'h1, 8'h00, 12'hf60, 3'h2, 21'h000001},
      '{16'h865f, 1'h1, 8'hf0, 12'h25f, 3'h2, 21'h0000f8},
      '{16'h8410, 1'h0, 8'h04, 12'h010, 3'h2, 21'h000004},
      '{16'hb220, 1'h0, 8'hfd, 12'h020, 3'h1, 21'h000000},
      '{16'hb220, 1'h0, 8'h02, 12'h020, 3'h0, 21'h000000},
      '{16'hafff, 1'h0, 8'h80, 12'h3ff, 3'h1, 21'h000000},
      '{16'hafff, 1'h0, 8'h7f, 12'h3ff, 3'h0, 21'h000000}};
   bbsd_decode DUT (.clk, .reset_n, .instr, .instr_valid, .pc_inc(21'h001000),
      .bank_select_register(4'h3), .ext_set_en, .index_base(12'h200), .file_rd_data,
      .q_phase, .file_rd_addr, .file_wr, .pc_load, .flush, .busy);
   initial forever #20 clk = ~clk;
   task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] s);
      comparisons++;
      if (s !== e)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Offer one word in Q4, then stop at the middle of its last phase
   task automatic issue(input bbsd_row_s r, input bit any);
      do @(negedge clk); while (q_phase !== 2'h2 || (!any && busy !== 1'b0));
      @(posedge clk);
      instr <= r.ins;
      instr_valid <= 1'b1;
      ext_set_en <= r.ext;
      file_rd_data <= r.rd;
      @(posedge clk);
      instr_valid <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic give_verdict;
      $display("num_errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog; a hang counts as a mismatch
   initial
   begin
      repeat (3000) @(posedge clk);
      num_errors++;
      give_verdict();
   end
   // Main sequence: table, then refusal during a flush
   initial
   begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk("idle", 21'h0, 21'({pc_load.load, file_wr.we, flush}));
      foreach (rows[i])
      begin
         issue(rows[i], 1'b0);
         chk("load", 21'(rows[i].lwf[2]), 21'(pc_load.load));
         chk("write", 21'(rows[i].lwf[1]), 21'(file_wr.we));
         if (rows[i].lwf[2])
            chk("target", rows[i].val, pc_load.target);
         else
            chk("addr", 21'(rows[i].adr), 21'(file_rd_addr));
         if (rows[i].lwf[1])
            chk("data", rows[i].val, 21'(file_wr.data));
         @(negedge clk);
         chk("flush", 21'(rows[i].lwf[0]), 21'(flush));
      end
      // A word offered at the Q4 that starts the flush is refused
      do @(negedge clk); while (q_phase !== 2'h2 || busy !== 1'b0);
      @(posedge clk);
      instr <= rows[0].ins;
      instr_valid <= 1'b1;
      file_rd_data <= rows[2].rd;
      @(posedge clk);
      instr <= rows[2].ins;
      repeat (4) @(posedge clk);
      instr_valid <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("dropped", 21'h0, 21'(file_wr.we));
      chk("flushing", 21'h1, 21'(flush));
      give_verdict();
   end
endmodule
